// *** design/spi_rx_if.sv ***
// Carrier between the transceiver core and its SPI slave shifter
`default_nettype none

interface spi_rx_if;
  logic sck_rise;
  logic mosi;
  logic cs_active;
  logic frame_end;
  logic enable;
  logic soft_reset;
  logic [3:0] char_bits;
  logic [7:0] data;
  logic done;
  logic overlen;
  logic corrupt;

  modport core (
    output sck_rise, mosi, cs_active, frame_end, enable, soft_reset, char_bits,
    input data, done, overlen, corrupt
  );
  modport shifter (
    input sck_rise, mosi, cs_active, frame_end, enable, soft_reset, char_bits,
    output data, done, overlen, corrupt
  );
endinterface : spi_rx_if

`default_nettype wire

// *** design/spi_slave_shifter.sv ***
// SPI slave receive shifter with over-length detection and its lingering fault
`include "usart_defs.svh"
`default_nettype none

module spi_slave_shifter (
  input wire logic mclk,
  input wire logic reset_n,
  spi_rx_if.shifter link
);

  typedef struct packed {
    logic [7:0] shift;
    logic [3:0] count;
    logic taint;
    logic [7:0] data;
    logic done;
    logic overlen;
    logic corrupt;
  } shifter_state_t;

  shifter_state_t cur;
  shifter_state_t next_cur;
  logic [7:0] mask;

  // One mask bit per data bit; only the configured character length survives
  for (genvar gi = 0; gi < 8; gi++) begin : g_mask
    assign mask[gi] = (4'(gi) < link.char_bits);
  end

  // Shift on sampled clock edges, judge the frame when select goes away
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.overlen = 1'b0;
    if (!link.enable || link.soft_reset) begin
      // Disable and soft reset clear the shifter but not the taint
      next_cur.shift = 8'h00;
      next_cur.count = 4'h0;
    end else if (link.cs_active && link.sck_rise) begin
      next_cur.shift = {cur.shift[6:0], link.mosi};
      if (cur.count != `SPI_COUNT_MAX) begin
        next_cur.count = cur.count + 4'h1;
      end
    end else if (link.frame_end) begin
      if (cur.count > link.char_bits) begin
        next_cur.overlen = 1'b1;
        next_cur.taint = 1'b1;
      end else if (cur.count == link.char_bits) begin
        // The first good frame after an over-length one is damaged
        next_cur.data = (cur.shift & mask) ^ (cur.taint ? `SPI_CORRUPT_MASK : 8'h00);
        next_cur.corrupt = cur.taint;
        next_cur.done = 1'b1;
        next_cur.taint = 1'b0;
      end
      next_cur.shift = 8'h00;
      next_cur.count = 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign link.data = cur.data;
  assign link.done = cur.done;
  assign link.overlen = cur.overlen;
  assign link.corrupt = cur.corrupt;

endmodule : spi_slave_shifter

`default_nettype wire

// *** design/usart_defs.svh ***
// Constants for the serial transceiver receive, flow-control and SPI slave logic
`ifndef USART_DEFS_SVH
`define USART_DEFS_SVH

// Value that every read of the smart-card error counter returns
`define ISO_ERROR_COUNT_READ 8'h00
// Width of the smart-card error counter
`define ISO_ERROR_COUNT_W 8
// Receive character width in bits
`define RX_DATA_W 8
// Character length is this base plus the two-bit length code (5 to 8 bits)
`define CHAR_BITS_BASE 4'h5
// Width of the SPI bit counter; saturates at its top value
`define SPI_COUNT_W 4
`define SPI_COUNT_MAX 4'hf
// Bit that is flipped in the character that follows an over-length frame
`define SPI_CORRUPT_MASK 8'h01
// Request-to-send level after reset
`define RTS_RESET_LEVEL 1'h0

`endif

// *** design/usart_errata_core.sv ***
// Serial transceiver core: RTS control, smart-card receive lockup, SPI slave receive
// SPI pins pass a two-flop synchroniser; a third flop only serves edge detection.
// Smart-card lockup is a four-state sequence; stray recovery strobes are ignored.
// Buffer-full from the receive DMA is wired in but never read, as in the silicon.
// The SPI over-length taint lives in the shifter; only reset_n or the next good frame clears it.
// Every output port is a field of the one state register, so no port is decoded.
// Outside handshake mode, force-high wins a clash of the two RTS commands.
`include "usart_defs.svh"
`default_nettype none

module usart_errata_core (
  input wire logic mclk,
  input wire logic reset_n,
  // Configuration
  input wire usart_pkg::serial_mode_t serial_mode,
  input wire logic [1:0] char_len,
  input wire logic rx_enable,
  // Command strobes, one cycle each
  input wire logic rx_soft_reset_cmd,
  input wire logic mode_write_strobe,
  input wire logic control_write_strobe,
  input wire logic rts_force_high_cmd,
  input wire logic rts_force_low_cmd,
  // Receive DMA buffer state and transmitter activity
  input wire logic dma_rx_buf_full,
  input wire logic tx_char_sent,
  // Smart-card receive character from the line receiver
  input wire logic iso_rx_char_strobe,
  input wire logic [7:0] iso_rx_char,
  // SPI slave pins
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic spi_cs_n,
  // Outputs
  output logic rts,
  output logic [7:0] iso_error_count,
  output logic iso_rx_valid,
  output logic [7:0] iso_rx_data,
  output logic iso_rx_stalled,
  output logic spi_rx_valid,
  output logic [7:0] spi_rx_data,
  output logic spi_overlen_error,
  output logic spi_rx_corrupt
);

  typedef struct packed {
    // Pin synchronisers; stage 1 feeds stage 2 only
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic mosi_s1;
    logic mosi_s2;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    // Flow control and smart-card receive
    logic rts;
    usart_pkg::iso_rx_state_t iso_state;
    logic iso_stalled;
    logic [7:0] iso_err;
    logic iso_valid;
    logic [7:0] iso_data;
    // SPI results and shifter drive
    logic sck_rise;
    logic frame_end;
    logic spi_valid;
    logic [7:0] spi_data;
    logic spi_err;
    logic spi_corrupt;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;

  spi_rx_if spi_link ();

  logic iso_mode;
  logic spi_mode;

  // Mode decodes; T0 and T1 share the smart-card receive path
  assign iso_mode = (serial_mode == usart_pkg::MODE_ISO_T0) ||
                    (serial_mode == usart_pkg::MODE_ISO_T1);
  assign spi_mode = (serial_mode == usart_pkg::MODE_SPI_SLAVE);

  // Next-state logic for the whole core
  always_comb begin
    next_cur = cur;

    // Two flops on every pin, third flop only for edge detection. Select is
    // kept in pin polarity so the reset value matches the idle pin and no
    // false end of frame follows reset.
    next_cur.sck_s1 = spi_sck;
    next_cur.sck_s2 = cur.sck_s1;
    next_cur.sck_s3 = cur.sck_s2;
    next_cur.mosi_s1 = spi_mosi;
    next_cur.mosi_s2 = cur.mosi_s1;
    next_cur.cs_s1 = spi_cs_n;
    next_cur.cs_s2 = cur.cs_s1;
    next_cur.cs_s3 = cur.cs_s2;
    next_cur.sck_rise = cur.sck_s2 & ~cur.sck_s3;
    // Select released: the pin went from low to high
    next_cur.frame_end = cur.cs_s2 & ~cur.cs_s3;

    // Request-to-send. Outside handshake mode force-high is checked first, so a clash
    // leaves the line deasserted, the safe side for the far transmitter.
    // dma_rx_buf_full is left unread on purpose: honouring it would hide the
    // stuck line that software has to work around.
    if (serial_mode == usart_pkg::MODE_HANDSHAKE) begin
      // Buffer-full is not honoured here; the line just stays low
      next_cur.rts = 1'b0;
    end else if (rts_force_high_cmd) begin
      next_cur.rts = 1'b1;
    end else if (rts_force_low_cmd) begin
      next_cur.rts = 1'b0;
    end else begin
      next_cur.rts = cur.rts;
    end

    // Error counter never counts; reads are always zero.
    // Software has to take error counts from elsewhere.
    next_cur.iso_err = `ISO_ERROR_COUNT_READ;

    // Smart-card receiver lockup and its recovery sequence. Each step waits for
    // its own strobe; a strobe out of turn is ignored rather than restarting,
    // so software that repeats a step does no harm.
    unique case (cur.iso_state)
      usart_pkg::ISO_RX_LIVE: begin
        if (serial_mode == usart_pkg::MODE_ISO_T1 && tx_char_sent) begin
          next_cur.iso_state = usart_pkg::ISO_RX_DEAD;
        end
      end
      usart_pkg::ISO_RX_DEAD: begin
        if (rx_soft_reset_cmd) begin
          next_cur.iso_state = usart_pkg::ISO_RX_NEED_MODE;
        end
      end
      usart_pkg::ISO_RX_NEED_MODE: begin
        if (mode_write_strobe) begin
          next_cur.iso_state = usart_pkg::ISO_RX_NEED_CTRL;
        end
      end
      usart_pkg::ISO_RX_NEED_CTRL: begin
        if (control_write_strobe) begin
          next_cur.iso_state = usart_pkg::ISO_RX_LIVE;
        end
      end
    endcase

    // Stall flag registered from the next state, so the port is a flop
    next_cur.iso_stalled = (next_cur.iso_state != usart_pkg::ISO_RX_LIVE);

    // Characters are dropped silently while the receiver is locked
    next_cur.iso_valid = 1'b0;
    if (iso_mode && rx_enable && iso_rx_char_strobe &&
        cur.iso_state == usart_pkg::ISO_RX_LIVE) begin
      next_cur.iso_valid = 1'b1;
      next_cur.iso_data = iso_rx_char;
    end

    // SPI results from the shifter, registered once more for the ports.
    // The extra stage costs a cycle of latency but keeps every port a flop.
    next_cur.spi_valid = spi_link.done;
    next_cur.spi_err = spi_link.overlen;
    if (spi_link.done) begin
      next_cur.spi_data = spi_link.data;
      next_cur.spi_corrupt = spi_link.corrupt;
    end
  end

  // State register; reset gives idle pins, RTS low, live receiver
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
      cur.rts <= `RTS_RESET_LEVEL;
      cur.iso_state <= usart_pkg::ISO_RX_LIVE;
      // Idle select pin is high
      cur.cs_s1 <= 1'b1;
      cur.cs_s2 <= 1'b1;
      cur.cs_s3 <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Shifter drive; length code maps onto 5 to 8 bits
  assign spi_link.sck_rise = cur.sck_rise;
  assign spi_link.mosi = cur.mosi_s2;
  assign spi_link.cs_active = ~cur.cs_s2;
  assign spi_link.frame_end = cur.frame_end;
  assign spi_link.enable = rx_enable & spi_mode;
  assign spi_link.soft_reset = rx_soft_reset_cmd;
  assign spi_link.char_bits = `CHAR_BITS_BASE + {2'h0, char_len};

  // Receive shifter; it keeps its own taint across disable and soft reset
  spi_slave_shifter shifter (
    .mclk(mclk),
    .reset_n(reset_n),
    .link(spi_link.shifter)
  );

  // Every output is a register field
  assign rts = cur.rts;
  assign iso_error_count = cur.iso_err;
  assign iso_rx_valid = cur.iso_valid;
  assign iso_rx_data = cur.iso_data;
  assign iso_rx_stalled = cur.iso_stalled;
  assign spi_rx_valid = cur.spi_valid;
  assign spi_rx_data = cur.spi_data;
  assign spi_overlen_error = cur.spi_err;
  assign spi_rx_corrupt = cur.spi_corrupt;

endmodule : usart_errata_core

`default_nettype wire

// *** design/usart_pkg.sv ***
// Types shared by the serial transceiver modules
`default_nettype none

package usart_pkg;
  // Operating modes chosen by the mode register
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_HANDSHAKE,
    MODE_ISO_T0,
    MODE_ISO_T1,
    MODE_SPI_SLAVE
  } serial_mode_t;

  // Smart-card receiver recovery sequence
  typedef enum logic [1:0] {
    ISO_RX_LIVE,
    ISO_RX_DEAD,
    ISO_RX_NEED_MODE,
    ISO_RX_NEED_CTRL
  } iso_rx_state_t;
endpackage : usart_pkg

`default_nettype wire

// *** test/spi_master_model.sv ***
// SPI master that drives the slave pins of the core
`default_nettype none
module spi_master_model (
  output logic sck,
  output logic mosi,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock parked low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    cs_n = 1'b1;
  end
  // n bits MSB first; 160 ns phases give four mclk each, above the minimum
  task frame(input logic [8:0] d, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #160 sck = 1'b1;
      #160 sck = 1'b0;
    end
    #160 cs_n = 1'b1;
    mosi = ~mosi; // Released line shows no stale bit
    #160;
  endtask : frame
endmodule : spi_master_model
`default_nettype wire

// *** test/usart_errata_core_checker.sv ***
// Port checker for the serial transceiver core
`default_nettype none
module usart_errata_core_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire usart_pkg::serial_mode_t serial_mode,
  input wire logic rx_enable,
  input wire logic rts_force_high_cmd,
  input wire logic rts_force_low_cmd,
  input wire logic tx_char_sent,
  input wire logic iso_rx_char_strobe,
  input wire logic [7:0] iso_rx_char,
  input wire logic rts,
  input wire logic [7:0] iso_error_count,
  input wire logic iso_rx_valid,
  input wire logic [7:0] iso_rx_data,
  input wire logic iso_rx_stalled,
  input wire logic spi_rx_valid,
  input wire logic spi_overlen_error,
  input wire logic spi_rx_corrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic hs;
  logic iso;
  logic taint;
  // Mode decodes
  assign hs = serial_mode == usart_pkg::MODE_HANDSHAKE;
  assign iso = serial_mode inside {usart_pkg::MODE_ISO_T0, usart_pkg::MODE_ISO_T1};
  // Over-length frame pending; only reset_n or the next good frame clears it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) taint <= 1'b0;
    else if (spi_overlen_error) taint <= 1'b1;
    else if (spi_rx_valid) taint <= 1'b0;
  end
  AST_ERR_ZERO: assert property (iso_error_count == 8'h00)
    else $error("error count not zero");
  AST_FORCE_HIGH: assert property (rts_force_high_cmd && !hs |=> rts)
    else $error("rts not forced high");
  AST_FORCE_LOW: assert property (
    rts_force_low_cmd && !rts_force_high_cmd && !hs |=> !rts) else $error("rts not forced low");
  AST_RTS_HOLD: assert property (
    !rts_force_high_cmd && !rts_force_low_cmd && !hs |=> $stable(rts)) else $error("rts moved");
  AST_HS_LOW: assert property (hs |=> !rts)
    else $error("rts high in handshake mode");
  AST_T1_STALL: assert property (
    serial_mode == usart_pkg::MODE_ISO_T1 && tx_char_sent && !iso_rx_stalled
    |=> iso_rx_stalled [*3]) else $error("no stall after transmit");
  AST_STALL_DROP: assert property (iso_rx_stalled && iso_rx_char_strobe |=> !iso_rx_valid)
    else $error("char accepted while stalled");
  AST_ISO_PASS: assert property (
    iso && rx_enable && !iso_rx_stalled && iso_rx_char_strobe && !tx_char_sent
    |=> iso_rx_valid && iso_rx_data == $past(iso_rx_char)) else $error("char lost");
  AST_SPI_EXCL: assert property (spi_overlen_error |-> !spi_rx_valid)
    else $error("data with over-length error");
  AST_TAINT: assert property (spi_rx_valid |-> spi_rx_corrupt == taint)
    else $error("corrupt flag wrong");
  cover property (spi_overlen_error);
  cover property (spi_rx_valid && spi_rx_corrupt);
  cover property ($rose(iso_rx_stalled));
endmodule : usart_errata_core_checker
bind usart_errata_core usart_errata_core_checker u_chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .serial_mode(serial_mode),
  .rx_enable(rx_enable),
  .rts_force_high_cmd(rts_force_high_cmd),
  .rts_force_low_cmd(rts_force_low_cmd),
  .tx_char_sent(tx_char_sent),
  .iso_rx_char_strobe(iso_rx_char_strobe),
  .iso_rx_char(iso_rx_char),
  .rts(rts),
  .iso_error_count(iso_error_count),
  .iso_rx_valid(iso_rx_valid),
  .iso_rx_data(iso_rx_data),
  .iso_rx_stalled(iso_rx_stalled),
  .spi_rx_valid(spi_rx_valid),
  .spi_overlen_error(spi_overlen_error),
  .spi_rx_corrupt(spi_rx_corrupt)
);
`default_nettype wire

// *** test/usart_errata_core_test.sv ***
// Self-checking bench for the serial transceiver core
`default_nettype none
module usart_errata_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  usart_pkg::serial_mode_t mode = usart_pkg::MODE_NORMAL;
  logic [1:0] clen = 2'h3;
  logic en = 1'b1;
  logic [5:0] cmd = 6'h00; // soft, mode, ctrl, high, low, tx
  logic full = 1'b0;
  logic istb = 1'b0;
  logic [7:0] ich = 8'h00;
  logic sck, mosi, cs_n, rts, ivld, istall, svld, sovl, scor, erts, etaint;
  logic [7:0] errc, idat, sdat;
  logic [31:0] rnd = 32'h0831;
  int n_errors = 0;
  int samples_checked = 0;
  usart_errata_core u_usart_errata_core (.mclk(mclk), .reset_n(reset_n), .serial_mode(mode),
    .char_len(clen), .rx_enable(en), .rx_soft_reset_cmd(cmd[5]), .mode_write_strobe(cmd[4]),
    .control_write_strobe(cmd[3]), .rts_force_high_cmd(cmd[2]), .rts_force_low_cmd(cmd[1]),
    .dma_rx_buf_full(full), .tx_char_sent(cmd[0]), .iso_rx_char_strobe(istb),
    .iso_rx_char(ich), .spi_sck(sck), .spi_mosi(mosi), .spi_cs_n(cs_n), .rts(rts),
    .iso_error_count(errc), .iso_rx_valid(ivld), .iso_rx_data(idat), .iso_rx_stalled(istall),
    .spi_rx_valid(svld), .spi_rx_data(sdat), .spi_overlen_error(sovl), .spi_rx_corrupt(scor));
  spi_master_model u_spi_master_model (.sck(sck), .mosi(mosi), .cs_n(cs_n));
  // 25 MHz clock
  initial forever #20 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle; outputs are settled at the following falling edge
  task pulse(input logic [5:0] c);
    @(negedge mclk); // Idle edge, so back-to-back strobes never share a time step
    cmd = c;
    @(negedge mclk);
    cmd = 6'h00;
  endtask : pulse
  task ichar(input logic [7:0] d);
    istb = 1'b1;
    ich = d;
    @(negedge mclk);
    istb = 1'b0;
    chk(errc, 8'h00);
  endtask : ichar
  // One SPI frame of n bits; the model keeps the lingering fault in etaint
  task spi(input int n, input logic [1:0] cl);
    logic [8:0] d;
    rnd = lfsr(rnd);
    d = rnd[8:0] & 9'((1 << n) - 1);
    clen = cl;
    u_spi_master_model.frame(d, n);
    repeat (12) begin
      @(negedge mclk);
      if (svld || sovl) break;
    end
    if (n > 5 + cl) begin
      chk(sovl, 8'h01);
      etaint = 1'b1;
    end else begin
      chk(svld, 8'h01);
      chk(sdat, d[7:0] ^ {7'h00, etaint});
      chk(scor, etaint);
      etaint = 1'b0;
    end
  endtask : spi
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the expected run of about 18 us
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    erts = 1'b0;
    etaint = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk(rts, 8'h00);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      full = rnd[3];
      pulse({3'h0, rnd[1:0], 1'b0});
      if (rnd[1]) erts = 1'b1;
      else if (rnd[0]) erts = 1'b0;
      chk(rts, erts);
    end
    // Workaround flow: force high on a full buffer, low once a fresh one is armed
    full = 1'b1;
    pulse(6'h04);
    chk(rts, 8'h01);
    full = 1'b0;
    pulse(6'h02);
    chk(rts, 8'h00);
    mode = usart_pkg::MODE_HANDSHAKE;
    full = 1'b1;
    pulse(6'h04);
    chk(rts, 8'h00);
    mode = usart_pkg::MODE_ISO_T1;
    pulse(6'h04);
    chk(rts, 8'h01);
    ichar(8'ha5);
    chk(idat, 8'ha5);
    pulse(6'h01);
    chk(istall, 8'h01);
    ichar(8'h5a);
    chk(ivld, 8'h00);
    pulse(6'h08); // Out of order, must be ignored
    pulse(6'h20);
    pulse(6'h10);
    chk(istall, 8'h01);
    pulse(6'h08);
    chk(istall, 8'h00);
    ichar(8'h3c);
    chk(ivld, 8'h01);
    chk(idat, 8'h3c);
    mode = usart_pkg::MODE_ISO_T0;
    pulse(6'h01);
    chk(istall, 8'h00);
    mode = usart_pkg::MODE_SPI_SLAVE;
    spi(8, 2'h3);
    spi(9, 2'h3);
    en = 1'b0;
    pulse(6'h20);
    en = 1'b1;
    spi(8, 2'h3);
    spi(8, 2'h3);
    spi(6, 2'h0);
    spi(5, 2'h0);
    complete_run();
  end
endmodule : usart_errata_core_test
`default_nettype wire
